/* File: hdl/gated_timer_cfg.svh */
// offsets, field positions, reset values and timing counts of the gated timer
// assumes a byte-addressed APB bus with one aligned 32-bit word per register
`ifndef GATED_TIMER_CFG_SVH
`define GATED_TIMER_CFG_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define ADDR_W 8
`define OFS_COUNT_LOW 8'h00
`define OFS_COUNT_HIGH 8'h04
`define OFS_CONTROL 8'h08
`define OFS_STATUS 8'h0C
`define OFS_PORT_DIR 8'h10
`define OFS_PIN_LEVEL 8'h14

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define BIT_ROLLOVER 0
`define BIT_PIN4 0
`define BIT_PIN5 1

// ----------------------------------------------------------------------------
// reset values and forced pin values
// ----------------------------------------------------------------------------
`define RST_CONTROL 8'h00
`define RST_PORT_DIR 2'h3
`define PINS_FORCED_DIR 2'h3
`define PINS_FORCED_LEVEL 2'h0

// ----------------------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------------------
// instruction clock is pclk divided by four; last phase of the four
`define INSTR_LAST_PHASE 2'h3
`define COUNT_ALL_ONES 16'hFFFF

`endif

/* File: hdl/gated_timer_pkg.sv */
// types shared by the gated sixteen-bit timer and its prescaler
// assumes gated_timer_cfg.svh is on the include path
`include "gated_timer_cfg.svh"

package gated_timer_pkg;

    typedef struct packed {
        logic [`ADDR_W-1:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    // bit order follows the control register, bit 7 first
    typedef struct packed {
        logic gate_polarity;
        logic gate_enable;
        logic [1:0] prescale_select;
        logic lp_osc_enable;
        logic sync_bypass;
        logic clock_source_select;
        logic timer_on;
    } ctrl_t;

    typedef enum logic [1:0] {
        WAIT_LOW = 2'b01,
        ARMED = 2'b10
    } arm_state_t;

    typedef struct packed {
        logic [2:0] count;
        logic toggle;
    } prescale_state_t;

    typedef struct packed {
        logic [15:0] count;
        ctrl_t ctrl;
        logic rollover_flag;
        logic [1:0] port_dir;
        logic [1:0] pin_dir_out;
        logic [1:0] phase;
        logic ext_s1;
        logic ext_s2;
        logic osc_s1;
        logic osc_s2;
        logic src_prev;
        logic gate_s1;
        logic gate_s2;
        logic [1:0] pins_s1;
        logic [1:0] pins_s2;
        logic [2:0] psc_sync;
        arm_state_t arm;
        logic wake;
        logic lp_osc_run;
        apb_rsp_t rsp;
    } timer_state_t;

endpackage : gated_timer_pkg

/* File: hdl/count_prescaler.sv */
// divide-by-1/2/4/8 prescaler for the count tick
// assumes tick_in is a one-cycle pulse on clk; clear has priority over counting
`timescale 1ns/1ps

module count_prescaler (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic tick_in,
    input wire logic [1:0] select,
    output logic tick_out,
    output logic toggle
);
    import gated_timer_pkg::*;

    prescale_state_t s;
    prescale_state_t next_s;
    logic [2:0] mask;

    always_comb
    begin
        next_s = s;
        mask = 3'((4'h1 << select) - 4'h1);
        tick_out = tick_in && ((s.count & mask) == mask);
        if (clear)
        begin
            next_s.count = 3'h0;
        end
        else if (tick_in)
        begin
            next_s.count = s.count + 3'h1;
        end
        // toggle carries the divided tick as a level for a synchroniser
        if (tick_out)
        begin
            next_s.toggle = ~s.toggle;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign toggle = s.toggle;

endmodule : count_prescaler

/* File: hdl/gated_sixteen_bit_timer.sv */
// gated sixteen-bit timer/counter with prescaler, APB register slave
// assumes pclk is the system clock (Fosc); pins and the crystal are sampled
// Overview of operation
// - 16-bit counter seen as two byte registers
// - byte writes load the running counter immediately
// - source select: instruction clock or external input
// - internal source advances per prescaled instruction group
// - external source counts rising edges
// - external count synchronised or bypassed per control
// - crystal oscillator may clock the counter
// - first rising edge needs prior falling edge
// - prescaler divides by 1, 2, 4, 8
// - prescaler hidden, cleared by count writes
// - oscillator enable starts crystal, runs in sleep
// - oscillator usable only with permitted system clock
// - oscillator forces pins input, levels read zero
// - bypass mode counts independent of phase clocks
// - async mode counts in sleep, overflow wakes
// - mode switch may lose or add one
// - wrap to zero sets rollover flag
// - prescale codes 00/01/10/11 give 1/2/4/8
// - timer on, optionally gated by gate pin
// - gate polarity selects active level
`timescale 1ns/1ps
`include "gated_timer_cfg.svh"

module gated_sixteen_bit_timer (
    input wire logic pclk,
    input wire logic presetn,
    input gated_timer_pkg::apb_req_t apb_req,
    output gated_timer_pkg::apb_rsp_t apb_rsp,
    input wire logic ext_count_input,
    input wire logic crystal_in,
    input wire logic gate_pin,
    input wire logic pin5_level,
    input wire logic pin4_level,
    input wire logic sleep,
    input wire logic internal_oscillator,
    input wire logic lp_osc_mode,
    output logic lp_osc_run,
    output logic pin5_direction,
    output logic pin4_direction,
    output logic rollover_flag,
    output logic wake
);
    import gated_timer_pkg::*;

    timer_state_t s;
    timer_state_t next_s;

    // ------------------------------------------------------------------------
    // register read mux
    // ------------------------------------------------------------------------
    function automatic logic [32:0] read_word(input logic [`ADDR_W-1:0] addr,
                                              input timer_state_t st);
        logic [32:0] r;
        r = {1'b0, 32'h0};
        case (addr)
            `OFS_COUNT_LOW: r[7:0] = st.count[7:0];
            `OFS_COUNT_HIGH: r[7:0] = st.count[15:8];
            `OFS_CONTROL: r[7:0] = st.ctrl;
            `OFS_STATUS: r[`BIT_ROLLOVER] = st.rollover_flag;
            `OFS_PORT_DIR: r[1:0] = st.lp_osc_run ? `PINS_FORCED_DIR : st.port_dir;
            `OFS_PIN_LEVEL: r[1:0] = st.lp_osc_run ? `PINS_FORCED_LEVEL : st.pins_s2;
            default: r[32] = 1'b1;
        endcase
        return r;
    endfunction : read_word

    logic setup;
    logic wr;
    logic wr_low;
    logic wr_high;
    logic count_wr;
    logic [32:0] rd;
    logic ext_level;
    logic ext_rise;
    logic ext_fall;
    logic instr_tick;
    logic gate_active;
    logic run;
    logic src_tick;
    logic psc_tick;
    logic psc_toggle;
    logic sync_inc;
    logic inc;
    logic wrap;

    // ------------------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------------------
    count_prescaler u_prescaler (
        .clk(pclk),
        .rst_n(presetn),
        .clear(count_wr),
        .tick_in(src_tick),
        .select(s.ctrl.prescale_select),
        .tick_out(psc_tick),
        .toggle(psc_toggle)
    );

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb
    begin
        next_s = s;

        // ----------------------------------------------------------------
        // apb: answer one cycle after setup, write lands at the access edge
        // ----------------------------------------------------------------
        setup = apb_req.psel && !apb_req.penable;
        rd = read_word(apb_req.paddr, s);
        wr = apb_req.psel && apb_req.penable && s.rsp.pready && apb_req.pwrite &&
             !s.rsp.pslverr;
        wr_low = wr && (apb_req.paddr == `OFS_COUNT_LOW);
        wr_high = wr && (apb_req.paddr == `OFS_COUNT_HIGH);
        count_wr = wr_low || wr_high;
        next_s.rsp.pready = setup;
        if (setup)
        begin
            next_s.rsp.prdata = rd[31:0];
            next_s.rsp.pslverr = rd[32];
        end

        // ----------------------------------------------------------------
        // pin samplers, two stages each before use
        // ----------------------------------------------------------------
        next_s.ext_s1 = ext_count_input;
        next_s.ext_s2 = s.ext_s1;
        next_s.osc_s1 = crystal_in;
        next_s.osc_s2 = s.osc_s1;
        next_s.gate_s1 = gate_pin;
        next_s.gate_s2 = s.gate_s1;
        next_s.pins_s1 = {pin5_level, pin4_level};
        next_s.pins_s2 = s.pins_s1;

        // ----------------------------------------------------------------
        // oscillator is a level kept through sleep
        // ----------------------------------------------------------------
        next_s.lp_osc_run = s.ctrl.lp_osc_enable &&
                            (internal_oscillator || lp_osc_mode);
        next_s.pin_dir_out = s.lp_osc_run ? `PINS_FORCED_DIR : s.port_dir;

        // ----------------------------------------------------------------
        // external source: crystal replaces the count pin while it runs
        // ----------------------------------------------------------------
        ext_level = s.lp_osc_run ? s.osc_s2 : s.ext_s2;
        next_s.src_prev = ext_level;
        ext_rise = ext_level && !s.src_prev;
        ext_fall = !ext_level && s.src_prev;

        case (s.arm)
            WAIT_LOW:
            begin
                if (s.ctrl.timer_on && s.ctrl.clock_source_select && ext_fall)
                begin
                    next_s.arm = ARMED;
                end
            end
            ARMED:
            begin
                if (!s.ctrl.timer_on || !s.ctrl.clock_source_select)
                begin
                    next_s.arm = WAIT_LOW;
                end
            end
            default: next_s.arm = WAIT_LOW;
        endcase

        // ----------------------------------------------------------------
        // instruction clock: one tick per four pclk, frozen in sleep
        // ----------------------------------------------------------------
        next_s.phase = sleep ? s.phase : s.phase + 2'h1;
        instr_tick = !sleep && (s.phase == `INSTR_LAST_PHASE);

        gate_active = (s.gate_s2 == s.ctrl.gate_polarity);
        run = s.ctrl.timer_on && (!s.ctrl.gate_enable || gate_active);
        if (s.ctrl.clock_source_select)
        begin
            src_tick = run && ext_rise && (s.arm == ARMED);
        end
        else
        begin
            src_tick = run && instr_tick;
        end

        // ----------------------------------------------------------------
        // synchronised path: prescaled toggle through two more stages
        // ----------------------------------------------------------------
        next_s.psc_sync = {s.psc_sync[1:0], psc_toggle};
        sync_inc = (s.psc_sync[2] != s.psc_sync[1]);
        if (s.ctrl.clock_source_select && s.ctrl.sync_bypass)
        begin
            inc = psc_tick;
        end
        else if (s.ctrl.clock_source_select)
        begin
            // switching modes may drop or add one step here
            inc = sync_inc && !sleep;
        end
        else
        begin
            inc = psc_tick;
        end

        // ----------------------------------------------------------------
        // counter: a software write wins over an increment in the same cycle
        // ----------------------------------------------------------------
        wrap = inc && (s.count == `COUNT_ALL_ONES);
        if (count_wr)
        begin
            if (wr_low)
            begin
                next_s.count[7:0] = apb_req.pwdata[7:0];
            end
            if (wr_high)
            begin
                next_s.count[15:8] = apb_req.pwdata[7:0];
            end
        end
        else if (inc)
        begin
            next_s.count = s.count + 16'h1;
        end

        // control and port registers
        if (wr && (apb_req.paddr == `OFS_CONTROL))
        begin
            next_s.ctrl = ctrl_t'(apb_req.pwdata[7:0]);
        end
        if (wr && (apb_req.paddr == `OFS_PORT_DIR))
        begin
            next_s.port_dir = apb_req.pwdata[1:0];
        end

        // ----------------------------------------------------------------
        // rollover flag: write one to clear, a wrap in the same cycle wins
        // ----------------------------------------------------------------
        if (wr && (apb_req.paddr == `OFS_STATUS) && apb_req.pwdata[`BIT_ROLLOVER])
        begin
            next_s.rollover_flag = 1'b0;
        end
        if (wrap && !count_wr)
        begin
            next_s.rollover_flag = 1'b1;
        end

        // wake request held until the processor leaves sleep
        if (!sleep)
        begin
            next_s.wake = 1'b0;
        end
        else if (wrap && !count_wr)
        begin
            next_s.wake = 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------------
    // the count value is not touched by reset; it holds whatever it had
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s.ctrl <= ctrl_t'(`RST_CONTROL);
            s.rollover_flag <= 1'b0;
            s.port_dir <= `RST_PORT_DIR;
            s.pin_dir_out <= `RST_PORT_DIR;
            s.phase <= 2'h0;
            s.ext_s1 <= 1'b0;
            s.ext_s2 <= 1'b0;
            s.osc_s1 <= 1'b0;
            s.osc_s2 <= 1'b0;
            s.src_prev <= 1'b0;
            s.gate_s1 <= 1'b0;
            s.gate_s2 <= 1'b0;
            s.pins_s1 <= 2'h0;
            s.pins_s2 <= 2'h0;
            s.psc_sync <= 3'h0;
            s.arm <= WAIT_LOW;
            s.wake <= 1'b0;
            s.lp_osc_run <= 1'b0;
            s.rsp <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    assign apb_rsp = s.rsp;
    assign lp_osc_run = s.lp_osc_run;
    assign pin5_direction = s.pin_dir_out[`BIT_PIN5];
    assign pin4_direction = s.pin_dir_out[`BIT_PIN4];
    assign rollover_flag = s.rollover_flag;
    assign wake = s.wake;

endmodule : gated_sixteen_bit_timer

/* File: dv/gated_sixteen_bit_timer_assertions.sv */
// port-level checker for the gated sixteen-bit timer
// assumes it is bound onto the timer and sees only its ports
`timescale 1ns/1ps
`include "gated_timer_cfg.svh"

module timer_port_checker (
    input wire logic pclk,
    input wire logic presetn,
    input gated_timer_pkg::apb_req_t apb_req,
    input gated_timer_pkg::apb_rsp_t apb_rsp,
    input wire logic sleep,
    input wire logic internal_oscillator,
    input wire logic lp_osc_mode,
    input wire logic lp_osc_run,
    input wire logic pin5_direction,
    input wire logic pin4_direction,
    input wire logic rollover_flag,
    input wire logic wake
);
    import gated_timer_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic setup;
    logic rd_setup;
    logic clr;
    assign setup = apb_req.psel && !apb_req.penable;
    assign rd_setup = setup && !apb_req.pwrite;
    // write-1 on the status bit is the only legal way down for the flag
    assign clr = apb_req.psel && apb_req.penable && apb_req.pwrite
        && apb_req.paddr == `OFS_STATUS && apb_req.pwdata[`BIT_ROLLOVER];
    // ----
    // assertions
    // ----
    a_ready_follows: assert property (setup |=> apb_rsp.pready)
        else $error("no ready after setup");
    a_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
        else $error("ready longer than one cycle");
    a_unmapped_err: assert property (setup && apb_req.paddr > `OFS_PIN_LEVEL
        |=> apb_rsp.pready && apb_rsp.pslverr)
        else $error("unmapped access without error");
    a_flag_sticky: assert property (rollover_flag && !clr |=> rollover_flag)
        else $error("rollover flag dropped by itself");
    a_pins_forced: assert property (lp_osc_run [*2] |-> pin5_direction && pin4_direction)
        else $error("pins not forced to input");
    a_osc_allowed: assert property (lp_osc_run |-> $past(internal_oscillator || lp_osc_mode))
        else $error("crystal running with wrong system clock");
    a_wake_cause: assert property ($rose(wake) |-> rollover_flag && $past(sleep))
        else $error("wake without rollover in sleep");
    a_dir_read: assert property (rd_setup && apb_req.paddr == `OFS_PORT_DIR && lp_osc_run
        |=> apb_rsp.prdata[1:0] == `PINS_FORCED_DIR)
        else $error("direction read not forced");
    a_level_read: assert property (rd_setup && apb_req.paddr == `OFS_PIN_LEVEL && lp_osc_run
        |=> apb_rsp.prdata[1:0] == `PINS_FORCED_LEVEL)
        else $error("pin level read not zero");
    cover property ($rose(rollover_flag));
    cover property ($rose(wake));
    cover property (apb_rsp.pready && apb_rsp.pslverr);
endmodule : timer_port_checker

bind gated_sixteen_bit_timer timer_port_checker u_timer_port_checker (.pclk, .presetn,
    .apb_req, .apb_rsp, .sleep, .internal_oscillator, .lp_osc_mode, .lp_osc_run,
    .pin5_direction, .pin4_direction, .rollover_flag, .wake);

/* File: dv/count_source_model.sv */
// external count pin and crystal seen from outside the timer
// assumes pulse trains are requested whole; both lines idle low between them
`timescale 1ns/1ps

module count_source_model (
    input wire logic pclk,
    input wire logic use_crystal,
    output logic ext_count_input,
    output logic crystal_in
);
    logic line = 1'b0;
    // the unused source stands still so it cannot leak counts
    assign ext_count_input = use_crystal ? 1'b0 : line;
    assign crystal_in = use_crystal ? line : 1'b0;
    // half period well above the pin sampler's limit
    task automatic pulses(input int n);
        repeat (n)
        begin
            repeat (8) @(posedge pclk);
            line <= 1'b1;
            repeat (8) @(posedge pclk);
            line <= 1'b0;
        end
    endtask : pulses
endmodule : count_source_model

/* File: dv/gated_sixteen_bit_timer_tb_top.sv */
// self-checking bench for the gated sixteen-bit timer
// assumes the checker binds itself from its own file
`timescale 1ns/1ps
`include "gated_timer_cfg.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("FAIL t=%0t got=%0h exp=%0h", $time, g, e); end end

module gated_sixteen_bit_timer_tb_top;
    import gated_timer_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    apb_req_t apb_req = '0;
    apb_rsp_t apb_rsp;
    logic gate_pin = 1'b0;
    logic [1:0] pins = 2'h2;
    logic sleep = 1'b0;
    logic internal_oscillator = 1'b0;
    logic lp_osc_mode = 1'b0;
    logic use_crystal = 1'b0;
    logic ext_count_input, crystal_in, lp_osc_run, pin5_direction, pin4_direction;
    logic rollover_flag, wake, err;
    logic [31:0] rd;
    int mismatches = 0;
    int total_checks = 0;

    gated_sixteen_bit_timer u_gated_sixteen_bit_timer (.pclk, .presetn, .apb_req, .apb_rsp,
        .ext_count_input, .crystal_in, .gate_pin, .pin5_level(pins[1]), .pin4_level(pins[0]),
        .sleep, .internal_oscillator, .lp_osc_mode, .lp_osc_run, .pin5_direction,
        .pin4_direction, .rollover_flag, .wake);
    count_source_model u_count_source_model (.pclk, .use_crystal, .ext_count_input,
        .crystal_in);

    initial forever #10 pclk = ~pclk;

    // ----
    // bus tasks
    // ----
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        apb_req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        // no wait length assumed; only the watchdog ends a stalled access
        do
        begin
            @(posedge pclk);
        end
        while (apb_rsp.pready !== 1'b1);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask : xfer

    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 32'h0);
        `CHK(rd, e)
    endtask : chk_rd

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish

    // ----
    // tests
    // ----
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        chk_rd(`OFS_CONTROL, 32'h0);
        chk_rd(`OFS_PORT_DIR, 32'h3);
        chk_rd(`OFS_STATUS, 32'h0);
        xfer(`OFS_COUNT_LOW, 1'b1, 32'hA5);
        xfer(`OFS_COUNT_HIGH, 1'b1, 32'h3C);
        chk_rd(`OFS_COUNT_HIGH, 32'h3C);
        // count must survive a second reset
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        chk_rd(`OFS_COUNT_LOW, 32'hA5);
        xfer(8'h40, 1'b0, 32'h0);
        `CHK(err, 1'b1)
        xfer(`OFS_PIN_LEVEL, 1'b1, 32'h0);
        chk_rd(`OFS_PIN_LEVEL, 32'h2);
        // directions follow the register while the crystal is off
        xfer(`OFS_PORT_DIR, 1'b1, 32'h1);
        repeat (2) @(posedge pclk);
        `CHK({pin5_direction, pin4_direction}, 2'h1)
        $display("register test done");
        // 64 divided cycles should give sixteen counts, one lost to phase
        for (int ps = 0; ps < 4; ps++)
        begin
            xfer(`OFS_CONTROL, 1'b1, 32'h1 | (ps << 4));
            xfer(`OFS_COUNT_HIGH, 1'b1, 32'h0);
            xfer(`OFS_COUNT_LOW, 1'b1, 32'h0);
            repeat (64 * (1 << ps) - 1) @(posedge pclk);
            xfer(`OFS_COUNT_LOW, 1'b0, 32'h0);
            `CHK(rd[7:0] inside {8'h0F, 8'h10}, 1'b1)
        end
        $display("prescale test done");
        for (int pol = 0; pol < 2; pol++)
        begin
            gate_pin <= ~pol[0];
            xfer(`OFS_CONTROL, 1'b1, {pol[0], 7'h41});
            xfer(`OFS_COUNT_LOW, 1'b1, 32'h0);
            repeat (40) @(posedge pclk);
            chk_rd(`OFS_COUNT_LOW, 32'h0);
            gate_pin <= pol[0];
            repeat (40) @(posedge pclk);
            xfer(`OFS_COUNT_LOW, 1'b0, 32'h0);
            `CHK(rd[7:0] inside {[8'h08:8'h0B]}, 1'b1)
        end
        $display("gate test done");
        for (int sb = 0; sb < 2; sb++)
        begin
            xfer(`OFS_CONTROL, 1'b1, 32'h0);
            xfer(`OFS_CONTROL, 1'b1, 32'h3 | (sb << 2));
            xfer(`OFS_COUNT_LOW, 1'b1, 32'h0);
            u_count_source_model.pulses(5);
            repeat (8) @(posedge pclk);
            chk_rd(`OFS_COUNT_LOW, 32'h4);
        end
        $display("external test done");
        use_crystal <= 1'b1;
        xfer(`OFS_CONTROL, 1'b1, 32'h8);
        repeat (3) @(posedge pclk);
        `CHK(lp_osc_run, 1'b0)
        internal_oscillator <= 1'b1;
        repeat (3) @(posedge pclk);
        `CHK(lp_osc_run, 1'b1)
        `CHK({pin5_direction, pin4_direction}, 2'h3)
        xfer(`OFS_PORT_DIR, 1'b1, 32'h0);
        chk_rd(`OFS_PORT_DIR, 32'h3);
        chk_rd(`OFS_PIN_LEVEL, 32'h0);
        `CHK({pin5_direction, pin4_direction}, 2'h3)
        // crystal start-up allowance before the counter is enabled
        repeat (100) @(posedge pclk);
        xfer(`OFS_COUNT_HIGH, 1'b1, 32'hFF);
        xfer(`OFS_COUNT_LOW, 1'b1, 32'hFE);
        xfer(`OFS_CONTROL, 1'b1, 32'hF);
        sleep <= 1'b1;
        u_count_source_model.pulses(4);
        repeat (8) @(posedge pclk);
        `CHK({rollover_flag, wake}, 2'h3)
        sleep <= 1'b0;
        chk_rd(`OFS_COUNT_LOW, 32'h1);
        `CHK(wake, 1'b0)
        xfer(`OFS_STATUS, 1'b1, 32'h1);
        chk_rd(`OFS_STATUS, 32'h0);
        $display("crystal test done");
        tally_and_finish();
    end

    initial
    begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        tally_and_finish();
    end
endmodule : gated_sixteen_bit_timer_tb_top
